/* File: core/tx_synth_defines.svh */
// offsets, field positions, reset values and timing counts of the transmitter configuration block
`ifndef TX_SYNTH_DEFINES_SVH
`define TX_SYNTH_DEFINES_SVH
`define ADDR_BAUD_POST     8'h01
`define ADDR_BAUD_PRE      8'h02
`define ADDR_AMP_POWER     8'h06
`define ADDR_CARRIER_HIGH  8'h0b
`define ADDR_CARRIER_MID   8'h0c
`define ADDR_CARRIER_LOW   8'h0d
`define ADDR_DEVIATION     8'h0e
`define AMP_LEVEL_MSB      2
`define AMP_LEVEL_LSB      0
`define AMP_LEVEL_RESET    3'h0
`define AMP_LEVEL_MAX      3'h7
`define POST_DIV_MSB       2
`define POST_DIV_RESET     3'h1
`define PRE_DIV_RESET      8'h03
`define DEV_MSB            6
`define XO_DIV_RESET       3'h5
`define CARRIER_RESET      24'h000000
`define DEV_RESET          7'h00
`define CLK_SYS_KHZ        200000
`define CLOCK_OUTPUT_PIN_KHZ         800
`define CLOCK_OUTPUT_PIN_HALF_CYC    ((`CLK_SYS_KHZ / `CLOCK_OUTPUT_PIN_KHZ) / 2)
`endif

/* File: core/tx_synth_pkg.sv */
// types shared by the transmitter configuration block
package tx_synth_pkg;
	typedef enum logic [1:0] {
		ModeI2c,
		ModePresetA,
		ModePresetB,
		ModePresetC
	} iface_mode_t;
	typedef enum {
		TxIdle,
		TxRun
	} tx_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage : tx_synth_pkg

/* File: core/baud_tick_gen.sv */
// baud tick generator: reference divider, integer stage and power-of-two stage
`timescale 1ns/1ps
`default_nettype none
`include "tx_synth_defines.svh"
module baud_tick_gen (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] xoDivRatio,
	input  wire logic [7:0] integerStage,
	input  wire logic [2:0] powerStage,
	output logic            baudTick
);
	logic [2:0]  refCnt_reg, refCnt_next;
	logic [7:0]  preCnt_reg, preCnt_next;
	logic [6:0]  powCnt_reg, powCnt_next;
	logic        tick_reg, tick_next;
	logic        refTick, preTick;
	logic [6:0]  powLast;

	// last count of the 2^(1+post) stage for post 0 to 6; post 7 also gives 127, a 2^7 stage
	assign powLast  = 7'(({6'h00, 1'b1} << (7'(powerStage) + 7'h01)) - 7'h01);
	assign refTick  = (refCnt_reg == 3'(xoDivRatio - 3'h1)) || (xoDivRatio == 3'h0);
	assign preTick  = refTick && (preCnt_reg == 8'h00);
	assign baudTick = tick_reg;

	always_comb begin
		refCnt_next = refCnt_reg;
		preCnt_next = preCnt_reg;
		powCnt_next = powCnt_reg;
		tick_next   = 1'b0;
		if (!run) begin
			refCnt_next = 3'h0;
			preCnt_next = integerStage;
			powCnt_next = 7'h00;
		end else if (refTick) begin
			refCnt_next = 3'h0;
			// reload from the pre-divider gives 1+pre reference periods
			preCnt_next = (preCnt_reg == 8'h00) ? integerStage : preCnt_reg - 8'h01;
			if (preTick) begin
				powCnt_next = (powCnt_reg >= powLast) ? 7'h00 : powCnt_reg + 7'h01;
				tick_next   = (powCnt_reg >= powLast);
			end
		end else begin
			refCnt_next = refCnt_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			refCnt_reg <= 3'h0;
			preCnt_reg <= `PRE_DIV_RESET;
			powCnt_reg <= 7'h00;
			tick_reg   <= 1'b0;
		end else begin
			refCnt_reg <= refCnt_next;
			preCnt_reg <= preCnt_next;
			powCnt_reg <= powCnt_next;
			tick_reg   <= tick_next;
		end
	end
endmodule : baud_tick_gen
`default_nettype wire

/* File: core/tx_synth_and_baud_config.sv */
// register file, synthesizer word, baud timing and data path of the transmitter
`timescale 1ns/1ps
`default_nettype none
`include "tx_synth_defines.svh"
module tx_synth_and_baud_config (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  preset_select_low,
	input  wire logic                  preset_select_high,
	input  wire logic                  serial_tx_input_pin,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regAddr,
	input  wire tx_synth_pkg::reg_byte_t regWData,
	output tx_synth_pkg::reg_byte_t    regRData,
	input  wire logic                  fifoValid,
	input  wire logic                  fifoBit,
	input  wire logic                  txStart,
	output logic                       fifoTake,
	output logic                       clock_output_pin,
	output logic                       clockOutEnable,
	output tx_synth_pkg::iface_mode_t  ifaceMode,
	output logic                       txActive,
	output logic                       txSymbol,
	output logic [2:0]                 amp_level_code,
	output logic [23:0]                synthWord
);
	import tx_synth_pkg::*;

	reg_byte_t   rdata_reg, rdata_next;
	logic [2:0]  amp_reg, amp_next;
	logic [2:0]  post_reg, post_next;
	logic [7:0]  pre_reg, pre_next;
	logic [2:0]  crystal_divide_ratio_reg, crystal_divide_ratio_next;
	logic [23:0] carrier_reg, carrier_next;
	logic [6:0]  dev_reg, dev_next;
	logic [23:0] synth_reg, synth_next;
	logic        sel0Meta_reg, sel0Sync_reg, sel1Meta_reg, sel1Sync_reg;
	logic        dinMeta_reg, dinSync_reg;
	tx_state_t   state_reg, state_next;
	logic        sym_reg, sym_next;
	logic [7:0]  clkCnt_reg, clkCnt_next;
	logic        clock_output_pin_reg, clock_output_pin_next;
	logic        baudTick;
	logic        i2cMode;
	logic        dataBit;

	// pins come from outside the clock domain
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel0Meta_reg <= 1'b0;
			sel0Sync_reg <= 1'b0;
			sel1Meta_reg <= 1'b0;
			sel1Sync_reg <= 1'b0;
			dinMeta_reg  <= 1'b0;
			dinSync_reg  <= 1'b0;
		end else begin
			sel0Meta_reg <= preset_select_low;
			sel0Sync_reg <= sel0Meta_reg;
			sel1Meta_reg <= preset_select_high;
			sel1Sync_reg <= sel1Meta_reg;
			dinMeta_reg  <= serial_tx_input_pin;
			dinSync_reg  <= dinMeta_reg;
		end
	end

	assign ifaceMode = iface_mode_t'({sel1Sync_reg, sel0Sync_reg});
	assign i2cMode   = (ifaceMode == ModeI2c);

	// register writes; each register changes only on its own address
	always_comb begin
		amp_next     = amp_reg;
		post_next    = post_reg;
		pre_next     = pre_reg;
		crystal_divide_ratio_next   = crystal_divide_ratio_reg;
		carrier_next = carrier_reg;
		dev_next     = dev_reg;
		if (regWrite) begin
			case (regAddr)
				`ADDR_AMP_POWER:    amp_next = regWData[`AMP_LEVEL_MSB:`AMP_LEVEL_LSB];
				`ADDR_BAUD_POST:    post_next = regWData[`POST_DIV_MSB:0];
				`ADDR_BAUD_PRE:     pre_next = regWData;
				`ADDR_CARRIER_HIGH: carrier_next[23:16] = regWData;
				`ADDR_CARRIER_MID:  carrier_next[15:8] = regWData;
				`ADDR_CARRIER_LOW:  carrier_next[7:0] = regWData;
				`ADDR_DEVIATION:    dev_next = regWData[`DEV_MSB:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rdata_next = rdata_reg;
		if (regRead) begin
			case (regAddr)
				`ADDR_AMP_POWER:    rdata_next = {5'h00, amp_reg};
				`ADDR_BAUD_POST:    rdata_next = {5'h00, post_reg};
				`ADDR_BAUD_PRE:     rdata_next = pre_reg;
				`ADDR_CARRIER_HIGH: rdata_next = carrier_reg[23:16];
				`ADDR_CARRIER_MID:  rdata_next = carrier_reg[15:8];
				`ADDR_CARRIER_LOW:  rdata_next = carrier_reg[7:0];
				`ADDR_DEVIATION:    rdata_next = {1'b0, dev_reg};
				default:            rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			amp_reg     <= `AMP_LEVEL_RESET;
			post_reg    <= `POST_DIV_RESET;
			pre_reg     <= `PRE_DIV_RESET;
			crystal_divide_ratio_reg   <= `XO_DIV_RESET;
			carrier_reg <= `CARRIER_RESET;
			dev_reg     <= `DEV_RESET;
			rdata_reg   <= 8'h00;
		end else begin
			amp_reg     <= amp_next;
			post_reg    <= post_next;
			pre_reg     <= pre_next;
			crystal_divide_ratio_reg   <= crystal_divide_ratio_next;
			carrier_reg <= carrier_next;
			dev_reg     <= dev_next;
			rdata_reg   <= rdata_next;
		end
	end

	// level code drives the amplifier directly, about 2.5 dB a step
	assign amp_level_code = amp_reg;
	assign regRData       = rdata_reg;

	baud_tick_gen u_baud (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.run          (state_reg == TxRun),
		.xoDivRatio   (crystal_divide_ratio_reg),
		.integerStage (pre_reg),
		.powerStage   (post_reg),
		.baudTick     (baudTick)
	);

	// i2c mode: one fifo symbol per baud tick; preset mode: the data pin
	assign fifoTake = i2cMode && (state_reg == TxRun) && baudTick && fifoValid;
	assign dataBit  = i2cMode ? sym_reg : dinSync_reg;

	always_comb begin
		state_next  = state_reg;
		sym_next    = sym_reg;
		clkCnt_next = clkCnt_reg;
		clock_output_pin_next = clock_output_pin_reg;
		case (state_reg)
			TxIdle: begin
				if (i2cMode && txStart) begin
					state_next = TxRun;
				end
			end
			TxRun: begin
				if (!i2cMode) begin
					state_next = TxIdle;
				end else if (baudTick) begin
					if (fifoValid) begin
						sym_next = fifoBit;
					end else begin
						state_next = TxIdle;
					end
				end
			end
			default: state_next = TxIdle;
		endcase
		// preset-mode clock output, free running while not in i2c mode
		if (i2cMode) begin
			clkCnt_next = 8'h00;
			clock_output_pin_next = 1'b0;
		end else if (clkCnt_reg == 8'(`CLOCK_OUTPUT_PIN_HALF_CYC - 1)) begin
			clkCnt_next = 8'h00;
			clock_output_pin_next = ~clock_output_pin_reg;
		end else begin
			clkCnt_next = clkCnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg  <= TxIdle;
			sym_reg    <= 1'b0;
			clkCnt_reg <= 8'h00;
			clock_output_pin_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			sym_reg    <= sym_next;
			clkCnt_reg <= clkCnt_next;
			clock_output_pin_reg <= clock_output_pin_next;
		end
	end

	// mark adds deviation to the carrier word, space uses it alone
	always_comb begin
		synth_next = dataBit ? carrier_reg + {17'h0, dev_reg} : carrier_reg;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			synth_reg <= `CARRIER_RESET;
		end else begin
			synth_reg <= synth_next;
		end
	end

	assign synthWord        = synth_reg;
	assign txActive         = (state_reg == TxRun) || !i2cMode;
	assign txSymbol         = dataBit;
	assign clock_output_pin = clock_output_pin_reg;
	assign clockOutEnable   = !i2cMode;
endmodule : tx_synth_and_baud_config
`default_nettype wire

/* File: test/tx_synth_chk.sv */
// port assertions for the transmitter configuration block
`timescale 1ns/1ps
`default_nettype none
module tx_synth_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire tx_synth_pkg::reg_byte_t regWData,
	input wire tx_synth_pkg::reg_byte_t regRData,
	input wire logic fifoValid,
	input wire logic fifoTake,
	input wire logic txActive,
	input wire logic clock_output_pin,
	input wire logic clockOutEnable,
	input wire tx_synth_pkg::iface_mode_t ifaceMode,
	input wire logic [2:0] amp_level_code
);
	import tx_synth_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_amp_write: assert property (regWrite && regAddr == 8'h06
		|=> amp_level_code == $past(regWData[2:0])) else $error("amp level not taken");
	chk_amp_reset: assert property ($past(rst) |-> amp_level_code == 3'h0)
		else $error("amp level not zero after reset");
	chk_dev_width: assert property (regRead && regAddr == 8'h0e
		|=> regRData[7] == 1'b0) else $error("deviation wider than 7 bits");
	chk_unmapped_zero: assert property (regRead && regAddr == 8'h03
		|=> regRData == 8'h00) else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!regRead |=> $stable(regRData))
		else $error("read data moved without read");
	chk_clk_enable: assert property (clockOutEnable == (ifaceMode != ModeI2c))
		else $error("clock pin enable wrong for mode");
	chk_clk_steady: assert property ($changed(clock_output_pin)
		|=> $stable(clock_output_pin) [*8]) else $error("clock pin toggles too fast");
	chk_take_valid: assert property (fifoTake |-> fifoValid && txActive)
		else $error("symbol taken from empty fifo");
	chk_take_gap: assert property (fifoTake |=> !fifoTake [*8])
		else $error("baud ticks too close");
endmodule : tx_synth_chk
`default_nettype wire

/* File: test/host_fifo_model.sv */
// host side symbol source for the transmit fifo head
`timescale 1ns/1ps
`default_nettype none
module host_fifo_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic load,
	input wire logic [4:0] count,
	input wire logic [15:0] pattern,
	input wire logic fifoTake,
	output logic fifoValid,
	output logic fifoBit
);
	logic [15:0] sh_reg, sh_next;
	logic [4:0] cnt_reg, cnt_next;
	logic last_reg, last_next;
	always_comb begin
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		last_next = last_reg;
		if (load) begin
			sh_next = pattern;
			cnt_next = count;
		end else if (fifoTake && fifoValid) begin
			sh_next = {sh_reg[14:0], 1'b0};
			cnt_next = cnt_reg - 5'h1;
			last_next = sh_reg[15];
		end
	end
	always_ff @(posedge clk_sys) begin
		sh_reg <= rst ? 16'h0 : sh_next;
		cnt_reg <= rst ? 5'h0 : cnt_next;
		last_reg <= rst ? 1'b0 : last_next;
	end
	// empty fifo shows no stale symbol
	assign fifoValid = cnt_reg != 5'h0;
	assign fifoBit = fifoValid ? sh_reg[15] : ~last_reg;
endmodule : host_fifo_model
`default_nettype wire

/* File: test/test_tx_synth_and_baud_config.sv */
// testbench for the transmitter configuration block
`timescale 1ns/1ps
`default_nettype none
module test_tx_synth_and_baud_config;
	import tx_synth_pkg::*;
	logic clk_sys = 0, rst = 1, preset_select_low = 0, preset_select_high = 0;
	logic serial_tx_input_pin = 0, regWrite = 0, regRead = 0, txStart = 0, load = 0;
	logic [7:0] regAddr = 8'h0;
	reg_byte_t regWData = 8'h0, regRData;
	logic fifoValid, fifoBit, fifoTake, clock_output_pin, clockOutEnable, txActive, txSymbol;
	logic [4:0] count = 5'h0;
	logic [15:0] pattern = 16'h0;
	iface_mode_t ifaceMode;
	logic [2:0] amp_level_code;
	logic [23:0] synthWord;
	int n_fail = 0, cmp_count = 0, n;
	always #2.5 clk_sys = ~clk_sys;
	tx_synth_and_baud_config dut (.clk_sys, .rst, .preset_select_low, .preset_select_high,
		.serial_tx_input_pin, .regWrite, .regRead, .regAddr, .regWData, .regRData, .fifoValid,
		.fifoBit, .txStart, .fifoTake, .clock_output_pin, .clockOutEnable, .ifaceMode,
		.txActive, .txSymbol, .amp_level_code, .synthWord);
	host_fifo_model host (.clk_sys, .rst, .load, .count, .pattern, .fifoTake, .fifoValid,
		.fifoBit);
	task ck(input logic [23:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask : ck
	task complete_run;
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc
	task wr(input logic [7:0] a, d);
		regWrite = 1;
		regAddr = a;
		regWData = d;
		cyc(1);
		regWrite = 0;
		// one idle edge so a following call never re-raises the strobe at once
		cyc(1);
	endtask : wr
	task rd(input logic [7:0] a, e);
		regRead = 1;
		regAddr = a;
		cyc(1);
		regRead = 0;
		ck(regRData, e);
		cyc(1);
	endtask : rd
	// bounded wait for a baud take or a clock pin edge
	task wt(input bit onClk);
		logic p;
		p = clock_output_pin;
		n = 0;
		do begin
			cyc(1);
			n++;
			if (n > 400) begin
				n_fail++;
				complete_run();
			end
		end while (onClk ? clock_output_pin === p : fifoTake !== 1'b1);
	endtask : wt
	task s_reset;
		ck(amp_level_code, 3'h0);
		rd(8'h06, 8'h00);
		rd(8'h01, 8'h01);
		rd(8'h02, 8'h03);
		for (int a = 8'h0b; a <= 8'h0e; a++) rd(a[7:0], 8'h00);
	endtask : s_reset
	task s_regs;
		wr(8'h06, 8'hff);
		ck(amp_level_code, 3'h7);
		rd(8'h06, 8'h07);
		wr(8'h0e, 8'hff);
		rd(8'h0e, 8'h7f);
		wr(8'h03, 8'h5a);
		rd(8'h03, 8'h00);
		wr(8'h0b, 8'h12);
		wr(8'h0c, 8'h34);
		wr(8'h0d, 8'h56);
		rd(8'h0e, 8'h7f);
		ck(amp_level_code, 3'h7);
		wr(8'h0e, 8'h00);
		cyc(2);
		ck(synthWord, 24'h123456);
	endtask : s_regs
	task s_tx;
		wr(8'h01, 8'h01);
		wr(8'h02, 8'h04);
		rd(8'h01, 8'h01);
		rd(8'h02, 8'h04);
		wr(8'h0d, 8'h00);
		wr(8'h0e, 8'h21);
		// manchester zero byte; the first four symbols are sent
		pattern = 16'haaaa;
		count = 5'h4;
		load = 1;
		cyc(1);
		load = 0;
		txStart = 1;
		cyc(1);
		txStart = 0;
		wt(0);
		for (int i = 0; i < 4; i++) begin
			cyc(3);
			ck(synthWord, i % 2 ? 24'h123400 : 24'h123421);
			if (i < 3) begin
				wt(0);
				// ratio 5 times (1+4) times 2^(1+1) clocks per symbol
				ck(n + 3, 100);
			end
		end
		cyc(100);
		ck(txActive, 1'b0);
	endtask : s_tx
	task s_mode;
		for (int m = 1; m < 4; m++) begin
			{preset_select_high, preset_select_low} = m[1:0];
			cyc(4);
			ck(ifaceMode, m);
			ck(clockOutEnable, 1'b1);
		end
		serial_tx_input_pin = 1;
		cyc(4);
		ck({txActive, txSymbol}, 2'h3);
		ck(synthWord, 24'h123421);
		wt(1);
		wt(1);
		ck(n, 125);
		{preset_select_high, preset_select_low} = 2'h0;
		cyc(4);
		ck(clockOutEnable, 1'b0);
		ck(clock_output_pin, 1'b0);
	endtask : s_mode
	initial begin
		cyc(20);
		rst = 0;
		cyc(3);
		s_reset();
		s_regs();
		s_tx();
		s_mode();
		complete_run();
	end
endmodule : test_tx_synth_and_baud_config
bind tx_synth_and_baud_config tx_synth_chk chk (.clk_sys, .rst, .regWrite, .regRead, .regAddr,
	.regWData, .regRData, .fifoValid, .fifoTake, .txActive, .clock_output_pin, .clockOutEnable,
	.ifaceMode, .amp_level_code);
`default_nettype wire
